// ---- rtl/ua_core.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "ua_defs.svh"
module ua_core
  import ua_pkg::*;
#(
  parameter logic [15:0] DIV_INIT = `UA_DIV_RESET
)(
  input wire logic SYS_CLK, // System clock, 25 MHz.
  input wire logic SRST, // Synchronous reset, active high.
  input wire logic PSEL, // APB select.
  input wire logic PENABLE, // APB access phase.
  input wire logic PWRITE, // APB direction, high for write.
  input wire logic [11:0] PADDR, // APB byte address.
  input wire logic [31:0] PWDATA, // APB write data.
  output logic [31:0] PRDATA, // APB read data.
  output logic PREADY, // APB ready.
  output logic PSLVERR, // APB error for unmapped address.
  input wire logic SERIAL_INPUT, // Serial line input.
  output logic SOUT, // Serial line output.
  output logic DTR_OUT, // Terminal ready, modem control bit zero.
  output logic RTS_OUT, // Request to send, modem control bit one.
  output logic OUT1, // General output one.
  output logic OUT2 // General output two.
);

  ua_state_s r_reg;
  ua_state_s r_next;

  // Parity bit for a character; stick mode sends the inverse of polarity.
  function automatic logic par_bit(input logic [7:0] d, input logic [1:0] wl,
                                   input logic even_parity_select, input logic stick);
    logic [7:0] m;
    m = 8'hFF >> (2'h3 - wl);
    if (stick)
      par_bit = ~even_parity_select;
    else
      par_bit = (^(d & m)) ^ ~even_parity_select;
  endfunction : par_bit

  // Last data bit index for the selected word length.
  // The index is three bits wide, so an eight-bit word ends at seven.
  function automatic logic [2:0] last_bit(input logic [1:0] wl);
    last_bit = `UA_BASE_LAST + {1'b0, wl};
  endfunction : last_bit

  // All next-state logic; a holding write wins over a load, while receive status sets win over read clears.
  always_comb
  begin
    logic acc;
    logic wr;
    logic rd;
    logic bad;
    logic divisor_access_bit;
    logic [2:0] idx;
    logic [7:0] rv;
    logic [7:0] wd;
    logic [5:0] stop_end;
    logic [7:0] rx_data;
    acc = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    bad = 1'b0;
    divisor_access_bit = 1'b0;
    idx = 3'h0;
    rv = 8'h00;
    wd = 8'h00;
    stop_end = `UA_STOP1_TICKS;
    rx_data = 8'h00;
    r_next = r_reg;
    idx = PADDR[4:2];
    wd = PWDATA[7:0];
    divisor_access_bit = r_reg.line_control[`UA_LCR_DIVISOR_ACCESS_BIT];
    bad = (PADDR[11:5] != 7'h00) || (PADDR[1:0] != 2'h0);
    // Read multiplexer; reserved and upper bits read as zero.
    case (idx)
      `UA_IDX_DATA: rv = divisor_access_bit ? r_reg.div[7:0] : r_reg.rx_buffer;
      `UA_IDX_IER: rv = divisor_access_bit ? r_reg.div[15:8] : r_reg.interrupt_enable;
      `UA_IDX_IIR: rv = `UA_IIR_NONE;
      `UA_IDX_LCR: rv = r_reg.line_control;
      `UA_IDX_MCR: rv = r_reg.modem_control;
      `UA_IDX_LSR: rv = {1'b0, r_reg.tx_all_empty, r_reg.tx_holding_empty, r_reg.bi,
                         r_reg.fe, r_reg.pe, r_reg.oe, r_reg.dr};
      `UA_IDX_SCR: rv = r_reg.spare_byte;
      default: rv = 8'h00;
    endcase
    // One wait state: ready rises in the second access cycle.
    // A refused access still answers, so the bus never hangs.
    r_next.pready = 1'b0;
    r_next.pslverr = 1'b0;
    if (PSEL && PENABLE && !r_reg.pready)
    begin
      r_next.pready = 1'b1;
      r_next.pslverr = bad;
      r_next.prdata = bad ? 32'h00000000 : {24'h000000, rv};
    end
    acc = PSEL && PENABLE && r_reg.pready && !r_reg.pslverr;
    wr = acc && PWRITE;
    rd = acc && !PWRITE;

    // Sixteen-times sample clock as a one-cycle enable; zero acts as one.
    // A new divisor takes hold at once, so one period may come out short.
    r_next.tick = 1'b0;
    if ((r_reg.brg_cnt + 16'h0001 >= r_reg.div) || (r_reg.div == 16'h0000))
    begin
      r_next.brg_cnt = 16'h0000;
      r_next.tick = 1'b1;
    end
    else
      r_next.brg_cnt = r_reg.brg_cnt + 16'h0001;

    // Transmitter. A load takes the old holding value before a bus write.
    // Stop length is read live, not latched per word.
    case (r_reg.line_control[1:0])
      2'h0: stop_end = r_reg.line_control[`UA_LCR_STB] ? `UA_STOP15_TICKS
                                              : `UA_STOP1_TICKS;
      default: stop_end = r_reg.line_control[`UA_LCR_STB] ? `UA_STOP2_TICKS
                                                 : `UA_STOP1_TICKS;
    endcase
    case (r_reg.tx_st)
      TX_IDLE:
      begin
        r_next.tx_line = 1'b1;
        if (!r_reg.tx_holding_empty)
        begin
          r_next.tx_shift_reg = r_reg.tx_holding;
          r_next.tx_holding_empty = 1'b1;
          r_next.tx_all_empty = 1'b0;
          r_next.tx_cnt = 6'h00;
          r_next.tx_line = 1'b0;
          r_next.tx_st = TX_START;
        end
        else
          r_next.tx_all_empty = 1'b1;
      end
      TX_START, TX_DATA, TX_PAR:
      begin
        if (r_reg.tick)
        begin
          r_next.tx_cnt = r_reg.tx_cnt + 6'h01;
          if (r_reg.tx_cnt[3:0] == `UA_CELL_TICKS)
          begin
            r_next.tx_cnt = 6'h00;
            if (r_reg.tx_st == TX_START)
            begin
              r_next.tx_st = TX_DATA;
              r_next.tx_bit = 3'h0;
              r_next.tx_line = r_reg.tx_shift_reg[0];
            end
            else if (r_reg.tx_st == TX_DATA &&
                     r_reg.tx_bit != last_bit(r_reg.line_control[`UA_LCR_WLS]))
            begin
              r_next.tx_bit = r_reg.tx_bit + 3'h1;
              r_next.tx_line = r_reg.tx_shift_reg[r_reg.tx_bit + 3'h1];
            end
            else if (r_reg.tx_st == TX_DATA && r_reg.line_control[`UA_LCR_PEN])
            begin
              r_next.tx_st = TX_PAR;
              r_next.tx_line = par_bit(r_reg.tx_shift_reg, r_reg.line_control[`UA_LCR_WLS],
                                       r_reg.line_control[`UA_LCR_EPS],
                                       r_reg.line_control[`UA_LCR_STICK]);
            end
            else
            begin
              r_next.tx_st = TX_STOP;
              r_next.tx_line = 1'b1;
            end
          end
        end
      end
      TX_STOP:
      begin
        if (r_reg.tick)
        begin
          r_next.tx_cnt = r_reg.tx_cnt + 6'h01;
          if (r_reg.tx_cnt == stop_end)
          begin
            r_next.tx_cnt = 6'h00;
            // The next word only enters once this one has gone.
            if (!r_reg.tx_holding_empty)
            begin
              r_next.tx_shift_reg = r_reg.tx_holding;
              r_next.tx_holding_empty = 1'b1;
              r_next.tx_line = 1'b0;
              r_next.tx_st = TX_START;
            end
            else
            begin
              r_next.tx_all_empty = 1'b1;
              r_next.tx_st = TX_IDLE;
            end
          end
        end
      end
      default: r_next.tx_st = TX_IDLE;
    endcase
    // Break overrides the line but leaves the transmitter running.
    r_next.sout = r_next.tx_line && !r_reg.line_control[`UA_LCR_BRK];

    // Receiver, driven by the sample-clock enable.
    // The previous sample updates on every tick, so each edge counts once.
    // An edge may be seen one tick late; centre sampling absorbs it.
    if (r_reg.tick)
    begin
      r_next.rx_prev = SERIAL_INPUT;
      case (r_reg.rx_st)
        RX_IDLE:
        begin
          if (r_reg.rx_prev && !SERIAL_INPUT)
          begin
            r_next.rx_cnt = 4'h0;
            r_next.rx_st = RX_START;
          end
        end
        RX_START:
        begin
          r_next.rx_cnt = r_reg.rx_cnt + 4'h1;
          if (r_reg.rx_cnt == `UA_HALF_TICKS)
          begin
            r_next.rx_cnt = 4'h0;
            r_next.rx_bit = 3'h0;
            r_next.rx_shift_reg = 8'h00;
            // A spike that is gone by mid-cell is dropped as noise.
            r_next.rx_st = SERIAL_INPUT ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA:
        begin
          r_next.rx_cnt = r_reg.rx_cnt + 4'h1;
          if (r_reg.rx_cnt == `UA_CELL_TICKS)
          begin
            r_next.rx_shift_reg[r_reg.rx_bit] = SERIAL_INPUT;
            r_next.rx_bit = r_reg.rx_bit + 3'h1;
            if (r_reg.rx_bit == last_bit(r_reg.line_control[`UA_LCR_WLS]))
              r_next.rx_st = r_reg.line_control[`UA_LCR_PEN] ? RX_PAR : RX_STOP;
          end
        end
        RX_PAR:
        begin
          r_next.rx_cnt = r_reg.rx_cnt + 4'h1;
          if (r_reg.rx_cnt == `UA_CELL_TICKS)
          begin
            r_next.rx_par = SERIAL_INPUT;
            r_next.rx_st = RX_STOP;
          end
        end
        RX_STOP:
        begin
          r_next.rx_cnt = r_reg.rx_cnt + 4'h1;
          if (r_reg.rx_cnt == `UA_CELL_TICKS)
            r_next.rx_st = RX_IDLE;
        end
        default: r_next.rx_st = RX_IDLE;
      endcase
    end

    // Register writes; the holding write lands after any load above.
    // Writing while holding-empty is low overwrites the waiting character.
    if (wr)
    begin
      case (idx)
        `UA_IDX_DATA:
        begin
          if (divisor_access_bit)
            r_next.div[7:0] = wd;
          else
          begin
            r_next.tx_holding = wd;
            r_next.tx_holding_empty = 1'b0;
            r_next.tx_all_empty = 1'b0;
          end
        end
        `UA_IDX_IER:
        begin
          if (divisor_access_bit)
            r_next.div[15:8] = wd;
          else
            r_next.interrupt_enable = wd & `UA_IER_MASK;
        end
        `UA_IDX_LCR: r_next.line_control = wd;
        `UA_IDX_MCR: r_next.modem_control = wd & `UA_MCR_MASK;
        `UA_IDX_SCR: r_next.spare_byte = wd;
        default: r_next.spare_byte = r_reg.spare_byte;
      endcase
    end
    // Read side effects come first, so status set below wins.
    if (rd && idx == `UA_IDX_DATA && !divisor_access_bit)
      r_next.dr = 1'b0;
    if (rd && idx == `UA_IDX_LSR)
    begin
      r_next.oe = 1'b0;
      r_next.pe = 1'b0;
      r_next.fe = 1'b0;
      r_next.bi = 1'b0;
    end

    // Character complete at stop-bit centre: load buffer, set status.
    // Status rises mid stop bit, before the line is back to idle.
    if (r_reg.tick && r_reg.rx_st == RX_STOP &&
        r_reg.rx_cnt == `UA_CELL_TICKS)
    begin
      rx_data = r_reg.rx_shift_reg;
      r_next.rx_buffer = rx_data;
      r_next.dr = 1'b1;
      // A buffer read in this very cycle takes the old word: no overrun.
      if (r_reg.dr && !(rd && idx == `UA_IDX_DATA && !divisor_access_bit))
        r_next.oe = 1'b1;
      if (r_reg.line_control[`UA_LCR_PEN] &&
          r_reg.rx_par != par_bit(rx_data, r_reg.line_control[`UA_LCR_WLS],
                                  r_reg.line_control[`UA_LCR_EPS],
                                  r_reg.line_control[`UA_LCR_STICK]))
        r_next.pe = 1'b1;
      if (!SERIAL_INPUT)
        r_next.fe = 1'b1;
      if (!SERIAL_INPUT && rx_data == 8'h00 &&
          !(r_reg.line_control[`UA_LCR_PEN] && r_reg.rx_par))
        r_next.bi = 1'b1;
    end
  end

  // State register with synchronous reset.
  // Divisor resets to its parameter, so no setup is needed before a frame.
  always_ff @(posedge SYS_CLK)
  begin
    if (SRST)
    begin
      r_reg <= '0;
      r_reg.div <= DIV_INIT;
      r_reg.tx_holding_empty <= 1'b1;
      r_reg.tx_all_empty <= 1'b1;
      r_reg.tx_st <= TX_IDLE;
      r_reg.rx_st <= RX_IDLE;
      r_reg.tx_line <= 1'b1;
      r_reg.sout <= 1'b1;
      r_reg.rx_prev <= 1'b1;
    end
    else
      r_reg <= r_next;
  end

  // Outputs straight from state flip-flops.
  // Nothing sits between register and pin, so outputs never glitch.
  assign PRDATA = r_reg.prdata;
  assign PREADY = r_reg.pready;
  assign PSLVERR = r_reg.pslverr;
  assign SOUT = r_reg.sout;
  assign DTR_OUT = r_reg.modem_control[`UA_MCR_DTR];
  assign RTS_OUT = r_reg.modem_control[`UA_MCR_RTS];
  assign OUT1 = r_reg.modem_control[`UA_MCR_OUT1];
  assign OUT2 = r_reg.modem_control[`UA_MCR_OUT2];

endmodule : ua_core
`default_nettype wire

// ---- rtl/ua_defs.svh ----
`ifndef UA_DEFS_SVH
`define UA_DEFS_SVH
// Register word indices; the byte address is four times the index.
`define UA_IDX_DATA 3'h0
`define UA_IDX_IER 3'h1
`define UA_IDX_IIR 3'h2
`define UA_IDX_LCR 3'h3
`define UA_IDX_MCR 3'h4
`define UA_IDX_LSR 3'h5
`define UA_IDX_MSR 3'h6
`define UA_IDX_SCR 3'h7
// Line control fields.
`define UA_LCR_WLS 1:0
`define UA_LCR_STB 2
`define UA_LCR_PEN 3
`define UA_LCR_EPS 4
`define UA_LCR_STICK 5
`define UA_LCR_BRK 6
`define UA_LCR_DIVISOR_ACCESS_BIT 7
// Modem control fields; modem control and interrupt-enable write masks.
`define UA_MCR_DTR 0
`define UA_MCR_RTS 1
`define UA_MCR_OUT1 2
`define UA_MCR_OUT2 3
`define UA_MCR_MASK 8'h1F
`define UA_IER_MASK 8'h0F
// Reset and fixed read values.
`define UA_IIR_NONE 8'h01
`define UA_DIV_RESET 16'h0001
// Sample-clock counts: centre of start bit, one cell, stop lengths.
`define UA_HALF_TICKS 4'h7
`define UA_CELL_TICKS 4'hF
`define UA_STOP1_TICKS 6'h0F
`define UA_STOP15_TICKS 6'h17
`define UA_STOP2_TICKS 6'h1F
// Last data bit index for a five-bit character.
`define UA_BASE_LAST 3'h4
`endif

// ---- rtl/ua_pkg.sv ----
package ua_pkg;
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP}
    ua_tx_e;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP}
    ua_rx_e;
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [15:0] div;
    logic [15:0] brg_cnt;
    logic tick;
    logic [7:0] interrupt_enable;
    logic [7:0] line_control;
    logic [7:0] modem_control;
    logic [7:0] spare_byte;
    logic [7:0] tx_holding;
    logic tx_holding_empty;
    logic tx_all_empty;
    ua_tx_e tx_st;
    logic [7:0] tx_shift_reg;
    logic [2:0] tx_bit;
    logic [5:0] tx_cnt;
    logic tx_line;
    logic sout;
    ua_rx_e rx_st;
    logic rx_prev;
    logic [3:0] rx_cnt;
    logic [2:0] rx_bit;
    logic [7:0] rx_shift_reg;
    logic rx_par;
    logic [7:0] rx_buffer;
    logic dr;
    logic oe;
    logic pe;
    logic fe;
    logic bi;
  } ua_state_s;
endpackage : ua_pkg

// ---- verif/ua_core_properties.sv ----
`timescale 1ns/1ns
`default_nettype none
module ua_core_props (
  input wire logic SYS_CLK, // Clock.
  input wire logic SRST, // Reset.
  input wire logic PSEL, // Select.
  input wire logic PENABLE, // Access phase.
  input wire logic PWRITE, // Direction.
  input wire logic [11:0] PADDR, // Address.
  input wire logic [31:0] PWDATA, // Write data.
  input wire logic [31:0] PRDATA, // Read data.
  input wire logic PREADY, // Ready.
  input wire logic PSLVERR, // Error.
  input wire logic SERIAL_INPUT, // Line in.
  input wire logic SOUT, // Line out.
  input wire logic DTR_OUT, // Modem bit zero.
  input wire logic RTS_OUT, // Modem bit one.
  input wire logic OUT1, // Modem bit two.
  input wire logic OUT2 // Modem bit three.
);
  // Every check runs on the system clock and sleeps during reset.
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (SRST);

  chk_idle_line: assert property ($fell(SRST) |-> SOUT)
    else $error("Serial output not idle after reset.");
  chk_cell_hold: assert property ($fell(SOUT) |-> !SOUT [*8])
    else $error("Low cell on serial output too short.");
  chk_ready_pulse: assert property (PREADY |=> !PREADY)
    else $error("Ready held longer than one cycle.");
  chk_one_wait: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
    else $error("Ready not given after one wait state.");
  chk_err_quiet: assert property (PSLVERR |-> PREADY && PRDATA == 32'h0)
    else $error("Error answer carries data or no ready.");
  chk_unmapped_err: assert property (PSEL && PENABLE && !PREADY &&
    PADDR[11:5] != 7'h00 |=> PSLVERR)
    else $error("Unmapped address not refused.");
  chk_upper_zero: assert property (PREADY |-> PRDATA[31:8] == 24'h0)
    else $error("Upper read data bits not zero.");
  chk_break_low: assert property (PSEL && PENABLE && PREADY && PWRITE &&
    PADDR == 12'h00C && PWDATA[6] |-> ##[1:3] !SOUT)
    else $error("Break did not force the line low.");
endmodule : ua_core_props
bind ua_core ua_core_props u_ua_core_props (.SYS_CLK(SYS_CLK),
  .SRST(SRST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
  .PSLVERR(PSLVERR), .SERIAL_INPUT(SERIAL_INPUT), .SOUT(SOUT), .DTR_OUT(DTR_OUT),
  .RTS_OUT(RTS_OUT), .OUT1(OUT1), .OUT2(OUT2));
`default_nettype wire

// ---- verif/ua_line_peer.sv ----
`timescale 1ns/1ns
`default_nettype none
module ua_line_peer (
  input wire logic clk, // System clock.
  input wire logic sout, // Line from the block.
  output logic serial_input // Line into the block.
);
  // The line rests high, as a pulled-up line does.
  initial serial_input = 1'b1;

  // Sixteen clocks per cell, since the bench runs divisor one.
  task automatic send(input logic [11:0] f, input int n);
    for (int i = 0; i < n; i++)
    begin
      @(posedge clk);
      serial_input <= f[i];
      repeat (15) @(posedge clk);
    end
    @(posedge clk);
    serial_input <= 1'b1;
  endtask : send

  // A short low spike that a receiver must reject.
  task automatic glitch(input int n);
    @(posedge clk);
    serial_input <= 1'b0;
    repeat (n) @(posedge clk);
    serial_input <= 1'b1;
  endtask : glitch

  // Wait for a start edge, then sample each cell near its centre.
  task automatic recv(input int n, output logic [11:0] f, output logic ok);
    int k;
    f = 12'h000;
    for (k = 0; k < 4000; k++)
    begin
      @(posedge clk);
      if (sout === 1'b0)
        break;
    end
    ok = (k < 4000);
    repeat (7) @(posedge clk);
    f[0] = sout;
    for (int i = 1; i < n; i++)
    begin
      repeat (16) @(posedge clk);
      f[i] = sout;
    end
  endtask : recv
endmodule : ua_line_peer
`default_nettype wire

// ---- verif/ua_core_tb_top.sv ----
`timescale 1ns/1ns
`default_nettype none
module ua_core_tb_top;
  logic sys_clk, srst, psel, penable, pwrite, serial_input, sout, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  wire logic [3:0] modem;
  int fail_count, checks;

  // Free-running 25 MHz system clock.
  initial sys_clk = 1'b0;
  always #20 sys_clk = ~sys_clk;

  // Divisor one gives a sample tick on every clock, keeping frames short.
  ua_core #(.DIV_INIT(16'h0001)) u_ua_core (.SYS_CLK(sys_clk),
    .SRST(srst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .SERIAL_INPUT(serial_input), .SOUT(sout), .DTR_OUT(modem[0]),
    .RTS_OUT(modem[1]), .OUT1(modem[2]), .OUT2(modem[3]));
  ua_line_peer u_ua_line_peer (.clk(sys_clk), .sout(sout), .serial_input(serial_input));

  task automatic give_verdict();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : give_verdict

  task automatic chk(input string what, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask : chk

  // One bus transfer; the wait for ready is bounded.
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d, output logic [31:0] r, output logic e);
    int i;
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++)
    begin
      @(posedge sys_clk);
      if (pready === 1'b1)
        break;
    end
    if (i == 16)
    begin
      chk("ready", 32'h0, 32'h1);
      give_verdict();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, {24'h0, d}, r, e);
  endtask : wr

  task automatic rdc(input string what, input logic [11:0] a,
    input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(what, r, exp);
  endtask : rdc

  // Frame image: start, data from bit zero, parity, stop, then idle.
  function automatic logic [11:0] mkf(input logic [7:0] d,
    input logic [7:0] l, input logic perr, input logic ferr);
    int n;
    logic p;
    logic [11:0] f;
    n = int'(l[1:0]) + 5;
    f = {3'h7, d, 1'b0} | (12'hFFF << (n + 1));
    p = ^(d & ~(8'hFF << n)) ^ !l[4] ^ perr;
    if (l[3])
      f[n + 1] = p;
    f[n + 1 + int'(l[3])] = !ferr;
    return f;
  endfunction : mkf

  task automatic t_regs();
    logic [31:0] r;
    logic e;
    rdc("status", 12'h014, 32'h60);
    rdc("ident", 12'h008, 32'h01);
    apb(1'b0, 12'h020, 32'h0, r, e);
    chk("unmapped", {31'h0, e}, 32'h1);
    wr(12'h01C, 8'hA5);
    rdc("spare", 12'h01C, 32'hA5);
    wr(12'h010, 8'h0F);
    repeat (2) @(posedge sys_clk);
    chk("modem", {28'h0, modem}, 32'hF);
    wr(12'h010, 8'h00);
    wr(12'h00C, 8'h83);
    wr(12'h000, 8'h5A);
    wr(12'h004, 8'h3C);
    rdc("div low", 12'h000, 32'h5A);
    rdc("div high", 12'h004, 32'h3C);
    // Put the fast divisor back before any frame is sent.
    wr(12'h000, 8'h01);
    wr(12'h004, 8'h00);
    wr(12'h00C, 8'h03);
    rdc("line ctl", 12'h00C, 32'h03);
  endtask : t_regs

  // Two characters back to back through the double buffer.
  task automatic t_tx();
    logic [11:0] f;
    logic ok;
    fork
      u_ua_line_peer.recv(10, f, ok);
      begin
        wr(12'h000, 8'hA5);
        rdc("loaded", 12'h014, 32'h20);
        wr(12'h000, 8'h3C);
        rdc("both full", 12'h014, 32'h00);
      end
    join
    chk("frame a", {21'h0, ok, f[9:0]}, {21'h0, 2'h3, 8'hA5, 1'b0});
    rdc("waiting", 12'h014, 32'h00);
    fork
      u_ua_line_peer.recv(10, f, ok);
      begin
        repeat (40) @(posedge sys_clk);
        rdc("sending", 12'h014, 32'h20);
      end
    join
    chk("frame b", {21'h0, ok, f[9:0]}, {21'h0, 2'h3, 8'h3C, 1'b0});
    repeat (20) @(posedge sys_clk);
    rdc("tx done", 12'h014, 32'h60);
  endtask : t_tx

  // Every word length, parity polarity alternating.
  task automatic t_rx();
    logic [7:0] l;
    for (int i = 0; i < 4; i++)
    begin
      l = {3'h0, i[0], 1'b1, 1'b0, i[1:0]};
      wr(12'h00C, l);
      u_ua_line_peer.send(mkf(8'hB6, l, 1'b0, 1'b0), 12);
      rdc("rx ready", 12'h014, 32'h61);
      rdc("rx data", 12'h000, {24'h0, 8'hB6 & (8'hFF >> (3 - i))});
      rdc("rx clear", 12'h014, 32'h60);
    end
  endtask : t_rx

  task automatic t_err();
    wr(12'h00C, 8'h1B);
    u_ua_line_peer.send(mkf(8'h5A, 8'h1B, 1'b1, 1'b0), 12);
    rdc("parity", 12'h014, 32'h65);
    rdc("data pe", 12'h000, 32'h5A);
    u_ua_line_peer.send(mkf(8'h5A, 8'h1B, 1'b0, 1'b1), 12);
    rdc("framing", 12'h014, 32'h69);
    rdc("data fe", 12'h000, 32'h5A);
    u_ua_line_peer.send(mkf(8'h11, 8'h1B, 1'b0, 1'b0), 12);
    u_ua_line_peer.send(mkf(8'h22, 8'h1B, 1'b0, 1'b0), 12);
    rdc("overrun", 12'h014, 32'h63);
    rdc("data oe", 12'h000, 32'h22);
    u_ua_line_peer.glitch(4);
    // Wait past a whole frame, so an accepted spike would show data-ready.
    repeat (200) @(posedge sys_clk);
    rdc("noise", 12'h014, 32'h60);
  endtask : t_err

  task automatic t_break();
    wr(12'h00C, 8'h43);
    repeat (20) @(posedge sys_clk);
    chk("break", {31'h0, sout}, 32'h0);
    wr(12'h00C, 8'h03);
    repeat (4) @(posedge sys_clk);
    chk("unbreak", {31'h0, sout}, 32'h1);
  endtask : t_break

  // Five-bit word, long stop: all-empty still low past one stop length.
  task automatic t_stop();
    logic [11:0] f;
    logic ok;
    wr(12'h00C, 8'h04);
    fork
      u_ua_line_peer.recv(7, f, ok);
      wr(12'h000, 8'h35);
    join
    chk("frame 5", {24'h0, ok, f[6:0]}, {24'h0, 2'h3, 5'h15, 1'b0});
    repeat (8) @(posedge sys_clk);
    rdc("long stop", 12'h014, 32'h20);
    repeat (20) @(posedge sys_clk);
    rdc("stop done", 12'h014, 32'h60);
  endtask : t_stop

  // Reset for twelve clocks, then each scenario in turn.
  initial
  begin
    srst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    fail_count = 0;
    checks = 0;
    repeat (12) @(posedge sys_clk);
    srst <= 1'b0;
    t_regs();
    t_tx();
    t_rx();
    t_err();
    t_break();
    t_stop();
    give_verdict();
  end
endmodule : ua_core_tb_top
`default_nettype wire
